// [verilog/pdsr_pkg.sv]
// Package for the soft reset and ping policy block: states, commands, timing
package pdsr_pkg;
  typedef enum logic [3:0] {
    PDSR_ST_IDLE,
    PDSR_ST_SRC_TRANS,
    PDSR_ST_SRC_READY,
    PDSR_ST_SRC_PING,
    PDSR_ST_SEND_SR,
    PDSR_ST_SOFT_RESET,
    PDSR_ST_SRC_SEND_CAPS,
    PDSR_ST_SNK_WAIT_CAPS,
    PDSR_ST_SRC_HARD_RESET,
    PDSR_ST_SNK_HARD_RESET,
    PDSR_ST_SRC_DISCOVERY,
    PDSR_ST_ERR_RECOVERY
  } pdsr_state_t;

  typedef enum logic [2:0] {
    PDSR_MSG_NONE,
    PDSR_MSG_SOFT_RESET,
    PDSR_MSG_ACCEPT,
    PDSR_MSG_PING
  } pdsr_msg_t;

  typedef enum logic [1:0] {
    PDSR_DEV_PROVIDER,
    PDSR_DEV_PROV_CONS,
    PDSR_DEV_CONS_PROV,
    PDSR_DEV_CONSUMER
  } pdsr_dev_t;

  localparam int CLK_MHZ = 250;
  localparam int SENDER_RESP_US = 30;
  localparam int SENDER_RESP_CYC = SENDER_RESP_US * CLK_MHZ;
  localparam int HR_CNT_W = 4;
endpackage : pdsr_pkg

// [verilog/pdsr_timer_if.sv]
// Interface between the policy state machine and its response timer
`timescale 1ns/1ps
interface pdsr_timer_if;
  logic start;
  logic stop;
  logic running;
  logic expired;
  modport ctrl (output start, output stop, input running, input expired);
  modport tmr (input start, input stop, output running, output expired);
endinterface : pdsr_timer_if

// [verilog/pdsr_resp_timer.sv]
// Sender response timer: one-shot down counter with start and stop
`timescale 1ns/1ps
module pdsr_resp_timer #(
  parameter int COUNT = pdsr_pkg::SENDER_RESP_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  pdsr_timer_if.tmr tif
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LOAD = CW'(COUNT);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic run_reg;
  logic run_next;
  logic exp_reg;
  logic exp_next;
  wire last_tick = run_reg && (cnt_reg == ONE);

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (tif.start) begin
      cnt_next = LOAD;
      run_next = 1'b1;
    end else if (tif.stop) begin
      run_next = 1'b0;
    end else if (last_tick) begin
      run_next = 1'b0;
      exp_next = 1'b1;
    end else if (run_reg) begin
      cnt_next = cnt_reg - ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      exp_reg <= exp_next;
    end
  end

  assign tif.running = run_reg;
  assign tif.expired = exp_reg;

  a_expire_after_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(tif.expired) |-> $past(run_reg) && !run_reg)
    else $error("timer expired while not running");
endmodule : pdsr_resp_timer

// [verilog/pdsr_policy.sv]
// Policy engine: soft reset recovery and source ping for one port
// Operation
// - Protocol error enters send-soft-reset from any state; undelivered message does too, except in the two soft reset states.
// - Error in power role swap during supply transition goes straight to hard reset.
// - Error in data role swap invokes connector error recovery instead.
// - Source send-soft-reset: reset protocol, send Soft_Reset, start response timer.
// - Sink send-soft-reset: reset protocol, send Soft_Reset, start response timer.
// - Source send-soft-reset: Accept received moves to send-capabilities.
// - Sink send-soft-reset: Accept received moves to wait-for-capabilities.
// - Response timeout or transmit error in send-soft-reset goes to hard reset.
// - Hard reset target follows device type; Consumer/Provider source reverts to sink.
// - Received Soft_Reset enters soft-reset, resets protocol, then sends Accept.
// - Source: Accept sent after received Soft_Reset goes to send-capabilities.
// - Sink: Accept sent after received Soft_Reset goes to wait-for-capabilities.
// - Transmit error while sending Accept goes to role-selected hard reset.
// - Failed capabilities send with no partner attached goes to discovery.
// - Ping only from transition-supply or ready; entry requests a Ping.
// - Ping sent successfully returns to the state it came from.
// - Re-entry after ping only restarts the source activity timer.
// - Ping path can be disabled by configuration.
// - Hard reset entry requests physical signalling and increments the counter.
`timescale 1ns/1ps
module pdsr_policy #(
  parameter int RESP_CYC = pdsr_pkg::SENDER_RESP_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic role_is_src,
  input wire pdsr_pkg::pdsr_dev_t dev_type,
  input wire logic ping_en,
  input wire logic attached,
  input wire logic prs_in_transition,
  input wire logic drs_in_change,
  input wire logic prl_proto_err,
  input wire logic prl_tx_fail,
  input wire logic prl_tx_done,
  input wire logic prl_rx_soft_reset,
  input wire logic prl_rx_accept,
  input wire logic prl_reset_done,
  input wire logic dpm_enter_src_ready,
  input wire logic dpm_enter_src_trans,
  input wire logic dpm_enter_src_caps,
  input wire logic dpm_ping_req,
  input wire logic dpm_leave,
  output logic prl_reset_req,
  output logic tx_req,
  output pdsr_pkg::pdsr_msg_t tx_msg,
  output logic hard_reset_req,
  output logic [pdsr_pkg::HR_CNT_W-1:0] hard_reset_cnt,
  output logic type_c_recover,
  output logic src_act_restart,
  output logic entry_actions,
  output logic revert_default_snk,
  output pdsr_pkg::pdsr_state_t state
);
  // ==========================================================
  // Timer
  pdsr_timer_if tif ();

  pdsr_resp_timer #(.COUNT(RESP_CYC)) u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tif(tif)
  );

  // ==========================================================
  // State and decode
  pdsr_pkg::pdsr_state_t state_reg;
  pdsr_pkg::pdsr_state_t state_next;
  pdsr_pkg::pdsr_state_t ret_reg;
  pdsr_pkg::pdsr_state_t ret_next;
  logic step_reg;
  logic step_next;
  logic from_ping_reg;
  logic from_ping_next;
  logic [pdsr_pkg::HR_CNT_W-1:0] hr_cnt_reg;
  logic prl_reset_req_reg;
  logic tx_req_reg;
  pdsr_pkg::pdsr_msg_t tx_msg_reg;
  logic hard_reset_req_reg;
  logic type_c_recover_reg;
  logic src_act_restart_reg;
  logic entry_actions_reg;
  logic revert_reg;

  // Hard reset target by device type
  function automatic pdsr_pkg::pdsr_state_t hr_target(input logic src,
                                                      input pdsr_pkg::pdsr_dev_t dt);
    if (src && dt != pdsr_pkg::PDSR_DEV_CONS_PROV && dt != pdsr_pkg::PDSR_DEV_CONSUMER) begin
      return pdsr_pkg::PDSR_ST_SRC_HARD_RESET;
    end
    return pdsr_pkg::PDSR_ST_SNK_HARD_RESET;
  endfunction : hr_target

  wire any_err = prl_proto_err || prl_tx_fail;
  wire pdsr_pkg::pdsr_state_t hr_sel = hr_target(role_is_src, dev_type);
  wire in_send_sr = state_reg == pdsr_pkg::PDSR_ST_SEND_SR;
  wire in_soft_rst = state_reg == pdsr_pkg::PDSR_ST_SOFT_RESET;
  wire in_caps = state_reg == pdsr_pkg::PDSR_ST_SRC_SEND_CAPS;
  wire in_ping = state_reg == pdsr_pkg::PDSR_ST_SRC_PING;
  wire ping_ok_state = state_reg == pdsr_pkg::PDSR_ST_SRC_TRANS ||
                       state_reg == pdsr_pkg::PDSR_ST_SRC_READY;
  wire ping_go = role_is_src && ping_en && dpm_ping_req && ping_ok_state;
  wire state_change = state_next != state_reg;
  wire entering_hr = state_change && (state_next == pdsr_pkg::PDSR_ST_SRC_HARD_RESET ||
                                      state_next == pdsr_pkg::PDSR_ST_SNK_HARD_RESET);
  wire entering_ready = state_change && (state_next == pdsr_pkg::PDSR_ST_SRC_TRANS ||
                                         state_next == pdsr_pkg::PDSR_ST_SRC_READY);

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    step_next = step_reg;
    from_ping_next = 1'b0;
    // Received Soft_Reset outranks local errors
    // enter soft reset
    if (prl_rx_soft_reset) begin
      state_next = pdsr_pkg::PDSR_ST_SOFT_RESET;
      step_next = 1'b0;
    end else if (in_caps && prl_tx_fail && !attached) begin
      state_next = pdsr_pkg::PDSR_ST_SRC_DISCOVERY;
    // power swap error skips soft reset
    end else if (any_err && prs_in_transition) begin
      state_next = hr_sel;
    // data swap error goes to connector recovery
    end else if (any_err && drs_in_change) begin
      state_next = pdsr_pkg::PDSR_ST_ERR_RECOVERY;
    end else if ((in_send_sr || in_soft_rst) && prl_tx_fail) begin
      state_next = hr_sel;
    end else if (any_err) begin
      state_next = pdsr_pkg::PDSR_ST_SEND_SR;
      step_next = 1'b0;
    end else begin
      unique case (state_reg)
        pdsr_pkg::PDSR_ST_IDLE,
        pdsr_pkg::PDSR_ST_SRC_SEND_CAPS,
        pdsr_pkg::PDSR_ST_SNK_WAIT_CAPS,
        pdsr_pkg::PDSR_ST_SRC_DISCOVERY,
        pdsr_pkg::PDSR_ST_SRC_HARD_RESET,
        pdsr_pkg::PDSR_ST_SNK_HARD_RESET,
        pdsr_pkg::PDSR_ST_ERR_RECOVERY: begin
          if (dpm_enter_src_ready) begin
            state_next = pdsr_pkg::PDSR_ST_SRC_READY;
          end else if (dpm_enter_src_trans) begin
            state_next = pdsr_pkg::PDSR_ST_SRC_TRANS;
          end else if (dpm_enter_src_caps) begin
            state_next = pdsr_pkg::PDSR_ST_SRC_SEND_CAPS;
          end else if (dpm_leave) begin
            state_next = pdsr_pkg::PDSR_ST_IDLE;
          end
        end
        pdsr_pkg::PDSR_ST_SRC_TRANS,
        pdsr_pkg::PDSR_ST_SRC_READY: begin
          if (ping_go) begin
            state_next = pdsr_pkg::PDSR_ST_SRC_PING;
            ret_next = state_reg;
          end else if (dpm_enter_src_ready) begin
            state_next = pdsr_pkg::PDSR_ST_SRC_READY;
          end else if (dpm_enter_src_trans) begin
            state_next = pdsr_pkg::PDSR_ST_SRC_TRANS;
          end else if (dpm_leave) begin
            state_next = pdsr_pkg::PDSR_ST_IDLE;
          end
        end
        pdsr_pkg::PDSR_ST_SRC_PING: begin
          if (prl_tx_done) begin
            state_next = ret_reg;
            from_ping_next = 1'b1;
          end
        end
        pdsr_pkg::PDSR_ST_SEND_SR: begin
          if (!step_reg && prl_reset_done) begin
            step_next = 1'b1;
          end else if (step_reg && prl_rx_accept) begin
            state_next = role_is_src ? pdsr_pkg::PDSR_ST_SRC_SEND_CAPS
                                     : pdsr_pkg::PDSR_ST_SNK_WAIT_CAPS;
          end else if (tif.expired) begin
            state_next = hr_sel;
          end
        end
        pdsr_pkg::PDSR_ST_SOFT_RESET: begin
          if (!step_reg && prl_reset_done) begin
            step_next = 1'b1;
          end else if (step_reg && prl_tx_done) begin
            state_next = role_is_src ? pdsr_pkg::PDSR_ST_SRC_SEND_CAPS
                                     : pdsr_pkg::PDSR_ST_SNK_WAIT_CAPS;
          end
        end
        default: begin
          state_next = pdsr_pkg::PDSR_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Commands toward protocol layer and timer
  // Re-entry while already recovering restarts the sequence
  wire sr_restart = step_reg && !step_next;
  wire sr_entry = (state_change || sr_restart) && (state_next == pdsr_pkg::PDSR_ST_SEND_SR ||
                                                   state_next == pdsr_pkg::PDSR_ST_SOFT_RESET);
  wire sr_step_up = !step_reg && step_next;
  assign tif.start = in_send_sr && sr_step_up && !state_change;
  assign tif.stop = in_send_sr && (state_change || prl_rx_accept || sr_restart);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= pdsr_pkg::PDSR_ST_IDLE;
      ret_reg <= pdsr_pkg::PDSR_ST_SRC_READY;
      step_reg <= 1'b0;
      from_ping_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      step_reg <= step_next;
      from_ping_reg <= from_ping_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prl_reset_req_reg <= 1'b0;
      tx_req_reg <= 1'b0;
      tx_msg_reg <= pdsr_pkg::PDSR_MSG_NONE;
    end else begin
      prl_reset_req_reg <= sr_entry;
      tx_req_reg <= 1'b0;
      tx_msg_reg <= pdsr_pkg::PDSR_MSG_NONE;
      if (sr_step_up && !state_change) begin
        tx_req_reg <= 1'b1;
        tx_msg_reg <= in_send_sr ? pdsr_pkg::PDSR_MSG_SOFT_RESET : pdsr_pkg::PDSR_MSG_ACCEPT;
      end else if (state_change && state_next == pdsr_pkg::PDSR_ST_SRC_PING) begin
        tx_req_reg <= 1'b1;
        tx_msg_reg <= pdsr_pkg::PDSR_MSG_PING;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hr_cnt_reg <= '0;
      hard_reset_req_reg <= 1'b0;
      type_c_recover_reg <= 1'b0;
      src_act_restart_reg <= 1'b0;
      entry_actions_reg <= 1'b0;
      revert_reg <= 1'b0;
    end else begin
      hard_reset_req_reg <= entering_hr;
      if (entering_hr) begin
        hr_cnt_reg <= hr_cnt_reg + pdsr_pkg::HR_CNT_W'(1);
      end
      revert_reg <= entering_hr && role_is_src &&
                    state_next == pdsr_pkg::PDSR_ST_SNK_HARD_RESET;
      type_c_recover_reg <= state_change && state_next == pdsr_pkg::PDSR_ST_ERR_RECOVERY;
      // after ping only the activity timer restarts
      src_act_restart_reg <= entering_ready;
      entry_actions_reg <= entering_ready && !from_ping_next;
    end
  end

  assign prl_reset_req = prl_reset_req_reg;
  assign tx_req = tx_req_reg;
  assign tx_msg = tx_msg_reg;
  assign hard_reset_req = hard_reset_req_reg;
  assign hard_reset_cnt = hr_cnt_reg;
  assign type_c_recover = type_c_recover_reg;
  assign src_act_restart = src_act_restart_reg;
  assign entry_actions = entry_actions_reg;
  assign revert_default_snk = revert_reg;
  assign state = state_reg;

  // ==========================================================
  // Checks
  a_ping_needs_enable: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(in_ping) |-> $past(ping_en) && $past(ping_ok_state))
    else $error("ping entered while disabled or from wrong state");
  a_ping_sends_msg: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(in_ping) |-> tx_req && tx_msg == pdsr_pkg::PDSR_MSG_PING)
    else $error("ping entry without ping request");
  a_ping_returns: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_ping && prl_tx_done && !any_err && !prl_rx_soft_reset |=> state_reg == $past(ret_reg))
    else $error("ping did not return to origin");
  a_ping_reentry_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(in_ping) && ping_ok_state |-> src_act_restart && !entry_actions)
    else $error("re-entry after ping ran entry actions");
  a_rx_sr_entry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prl_rx_soft_reset |=> in_soft_rst && !step_reg)
    else $error("received soft reset not honoured");
  a_err_to_send_sr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prl_proto_err && !prl_rx_soft_reset && !prs_in_transition && !drs_in_change |=> in_send_sr)
    else $error("protocol error did not start soft reset");
  a_prs_hard_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
    any_err && prs_in_transition && !prl_rx_soft_reset && !(in_caps && !attached)
    |=> state_reg == $past(hr_sel))
    else $error("swap error did not go to hard reset");
  a_drs_recovery: assert property (@(posedge clk_sys) disable iff (!arst_n)
    any_err && drs_in_change && !prs_in_transition && !prl_rx_soft_reset
    && !(in_caps && !attached)
    |=> state_reg == pdsr_pkg::PDSR_ST_ERR_RECOVERY && type_c_recover)
    else $error("data swap error did not invoke recovery");
  a_sr_reset_then_tx: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(in_send_sr) |-> prl_reset_req && !tx_req)
    else $error("soft reset sent before protocol reset");
  a_timer_on_tx: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_send_sr && tx_req && tx_msg == pdsr_pkg::PDSR_MSG_SOFT_RESET |-> tif.running)
    else $error("response timer not running after soft reset sent");
  a_hr_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
    entering_hr |=> hard_reset_req && hr_cnt_reg == $past(hr_cnt_reg) + pdsr_pkg::HR_CNT_W'(1))
    else $error("hard reset entry without request or count");
  a_timeout_hr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_send_sr && tif.expired && !any_err && !prl_rx_soft_reset && !prl_rx_accept
    |=> state_reg == $past(hr_sel))
    else $error("response timeout did not hard reset");
  a_hr_by_type: assert property (@(posedge clk_sys) disable iff (!arst_n)
    role_is_src && dev_type == pdsr_pkg::PDSR_DEV_CONS_PROV
    |-> hr_sel == pdsr_pkg::PDSR_ST_SNK_HARD_RESET)
    else $error("consumer/provider source picked source hard reset");
  a_no_partner: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_caps && prl_tx_fail && !attached && !prl_rx_soft_reset
    |=> state_reg == pdsr_pkg::PDSR_ST_SRC_DISCOVERY)
    else $error("detached send failure did not go to discovery");
  a_src_accept_caps: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_send_sr && step_reg && prl_rx_accept && role_is_src && !any_err && !prl_rx_soft_reset
    |=> state_reg == pdsr_pkg::PDSR_ST_SRC_SEND_CAPS)
    else $error("accepted source soft reset did not resend capabilities");
  a_snk_accept_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_send_sr && step_reg && prl_rx_accept && !role_is_src && !any_err && !prl_rx_soft_reset
    |=> state_reg == pdsr_pkg::PDSR_ST_SNK_WAIT_CAPS)
    else $error("accepted sink soft reset did not wait for capabilities");
endmodule : pdsr_policy

// [tb/pdsr_prl_model.sv]
// Behavioural protocol layer and remote port facing the policy engine
`timescale 1ns/1ps
module pdsr_prl_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] dly,
  input wire logic fail_tx,
  input wire logic no_accept,
  input wire logic prl_reset_req,
  input wire logic tx_req,
  input wire pdsr_pkg::pdsr_msg_t tx_msg,
  output logic prl_reset_done,
  output logic prl_tx_done,
  output logic prl_tx_fail,
  output logic prl_rx_accept
);
  pdsr_pkg::pdsr_msg_t msg;
  initial begin
    prl_reset_done = 1'b0;
    prl_tx_done = 1'b0;
    prl_tx_fail = 1'b0;
    prl_rx_accept = 1'b0;
  end
  // ==========
  // Local reset, done after dly cycles
  always @(negedge clk_sys) begin
    if (arst_n === 1'b1 && prl_reset_req === 1'b1) begin
      repeat (dly - 4'h1) @(negedge clk_sys);
      prl_reset_done = 1'b1;
      @(negedge clk_sys);
      prl_reset_done = 1'b0;
    end
  end
  // ==========
  // Transmit outcome; a Soft_Reset is answered by the partner's Accept
  always @(negedge clk_sys) begin
    if (arst_n === 1'b1 && tx_req === 1'b1) begin
      msg = tx_msg;
      repeat (dly - 4'h1) @(negedge clk_sys);
      if (fail_tx) begin
        prl_tx_fail = 1'b1;
      end else if (msg == pdsr_pkg::PDSR_MSG_SOFT_RESET) begin
        prl_rx_accept = !no_accept;
      end else begin
        prl_tx_done = 1'b1;
      end
      @(negedge clk_sys);
      prl_tx_fail = 1'b0;
      prl_rx_accept = 1'b0;
      prl_tx_done = 1'b0;
    end
  end
endmodule : pdsr_prl_model

// [tb/tb.sv]
// Self-checking bench for the soft reset and ping policy engine
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic role_is_src = 1'b1;
  pdsr_pkg::pdsr_dev_t dev_type = pdsr_pkg::PDSR_DEV_PROVIDER;
  logic ping_en = 1'b1, attached = 1'b1, prs = 1'b0, drs = 1'b0;
  logic fail_tx = 1'b0, no_accept = 1'b0, rev_exp = 1'b0;
  logic [3:0] dly = 4'h1;
  logic [7:0] pv = 8'h00;
  logic rst_done, tx_done, tx_fail_m, rx_acc;
  logic prl_reset_req, tx_req, hard_reset_req, type_c_recover;
  logic src_act_restart, entry_actions, revert_default_snk;
  logic [3:0] hard_reset_cnt, hr_exp = 4'h0;
  pdsr_pkg::pdsr_msg_t tx_msg;
  pdsr_pkg::pdsr_state_t state, prev_st = pdsr_pkg::PDSR_ST_IDLE;
  pdsr_pkg::pdsr_state_t st_q[$];
  pdsr_pkg::pdsr_msg_t msg_q[$];
  logic [3:0] cnt_q[$];
  logic seen_rst = 1'b0, seen_tcr, seen_rev, seen_act, seen_ent;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [7:0] P_ERR = 8'h01, P_TXF = 8'h02, P_RXSR = 8'h04, P_RDY = 8'h08;
  localparam logic [7:0] P_TRN = 8'h10, P_CAPS = 8'h20, P_PING = 8'h40, P_LEAVE = 8'h80;

  always #2 clk_sys = ~clk_sys;

  pdsr_policy #(.RESP_CYC(8)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .role_is_src(role_is_src), .dev_type(dev_type), .ping_en(ping_en), .attached(attached),
    .prs_in_transition(prs), .drs_in_change(drs), .prl_proto_err(pv[0]),
    .prl_tx_fail(pv[1] | tx_fail_m), .prl_tx_done(tx_done), .prl_rx_soft_reset(pv[2]),
    .prl_rx_accept(rx_acc), .prl_reset_done(rst_done), .dpm_enter_src_ready(pv[3]),
    .dpm_enter_src_trans(pv[4]), .dpm_enter_src_caps(pv[5]), .dpm_ping_req(pv[6]),
    .dpm_leave(pv[7]), .prl_reset_req(prl_reset_req), .tx_req(tx_req), .tx_msg(tx_msg),
    .hard_reset_req(hard_reset_req), .hard_reset_cnt(hard_reset_cnt),
    .type_c_recover(type_c_recover), .src_act_restart(src_act_restart),
    .entry_actions(entry_actions), .revert_default_snk(revert_default_snk), .state(state));

  pdsr_prl_model PRL (.clk_sys(clk_sys), .arst_n(arst_n), .dly(dly), .fail_tx(fail_tx),
    .no_accept(no_accept), .prl_reset_req(prl_reset_req), .tx_req(tx_req), .tx_msg(tx_msg),
    .prl_reset_done(rst_done), .prl_tx_done(tx_done), .prl_tx_fail(tx_fail_m),
    .prl_rx_accept(rx_acc));

  // ==========
  // Compare and bookkeeping tasks
  task automatic chk_st(input pdsr_pkg::pdsr_state_t got, input pdsr_pkg::pdsr_state_t exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t state %s expected %s", $time, got.name(), exp.name());
    end
  endtask : chk_st

  task automatic chk_msg(input pdsr_pkg::pdsr_msg_t got, input pdsr_pkg::pdsr_msg_t exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t message %s expected %s", $time, got.name(), exp.name());
    end
  endtask : chk_msg

  task automatic chk_val(input logic [3:0] got, input logic [3:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic pulse(input logic [7:0] m);
    @(negedge clk_sys);
    pv = m;
    @(negedge clk_sys);
    pv = 8'h00;
  endtask : pulse

  task automatic exp_sr();
    st_q.push_back(pdsr_pkg::PDSR_ST_SEND_SR);
    msg_q.push_back(pdsr_pkg::PDSR_MSG_SOFT_RESET);
  endtask : exp_sr

  task automatic note_hr();
    logic src_hr;
    src_hr = role_is_src && (dev_type == pdsr_pkg::PDSR_DEV_PROVIDER ||
      dev_type == pdsr_pkg::PDSR_DEV_PROV_CONS);
    rev_exp = role_is_src && !src_hr;
    st_q.push_back(src_hr ? pdsr_pkg::PDSR_ST_SRC_HARD_RESET : pdsr_pkg::PDSR_ST_SNK_HARD_RESET);
    hr_exp = hr_exp + 4'h1;
    cnt_q.push_back(hr_exp);
  endtask : note_hr

  task automatic settle();
    int n;
    n = 0;
    while (st_q.size() + msg_q.size() + cnt_q.size() != 0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 300) chk_val(4'h0, 4'h1, "pending results");
    // Quiet window catches late or stray transitions
    repeat (16) @(negedge clk_sys);
  endtask : settle

  task automatic leave();
    st_q.push_back(pdsr_pkg::PDSR_ST_IDLE);
    pulse(P_LEAVE);
    settle();
  endtask : leave

  task automatic end_sim();
    $display("Counts: compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ==========
  // Output monitor
  always @(negedge clk_sys) begin
    if (arst_n === 1'b1) begin
      if (state !== prev_st) begin
        if (st_q.size() > 0) chk_st(state, st_q.pop_front());
        else chk_st(state, prev_st);
        prev_st = state;
      end
      if (tx_req === 1'b1) begin
        if (msg_q.size() > 0) chk_msg(tx_msg, msg_q.pop_front());
        else chk_msg(tx_msg, pdsr_pkg::PDSR_MSG_NONE);
        if (tx_msg !== pdsr_pkg::PDSR_MSG_PING) begin
          chk_val({3'h0, seen_rst}, 4'h1, "reset first");
        end
        seen_rst = 1'b0;
      end
      if (hard_reset_req === 1'b1) begin
        chk_val(hard_reset_cnt, cnt_q.size() ? cnt_q.pop_front() : 4'hx, "hr count");
      end
      if (prl_reset_req === 1'b1) seen_rst = 1'b1;
      if (type_c_recover === 1'b1) seen_tcr = 1'b1;
      if (revert_default_snk === 1'b1) seen_rev = 1'b1;
      if (src_act_restart === 1'b1) seen_act = 1'b1;
      if (entry_actions === 1'b1) seen_ent = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========
  // Test sequence
  initial begin
    void'($urandom(32'h1feb));
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    for (int r = 0; r < 2; r++) begin
      role_is_src = r[0];
      dly = 4'($urandom_range(1, 6));
      exp_sr();
      st_q.push_back(r ? pdsr_pkg::PDSR_ST_SRC_SEND_CAPS
                       : pdsr_pkg::PDSR_ST_SNK_WAIT_CAPS);
      pulse(r ? P_ERR : P_TXF);
      settle();
      leave();
    end
    $display("Test accepted_soft_reset done");
    for (int i = 0; i < 8; i++) begin
      role_is_src = i[2];
      dev_type = pdsr_pkg::pdsr_dev_t'(i[1:0]);
      no_accept = ~i[0];
      fail_tx = i[0];
      dly = 4'($urandom_range(1, 6));
      seen_rev = 1'b0;
      exp_sr();
      note_hr();
      pulse(P_ERR);
      settle();
      chk_val({3'h0, seen_rev}, {3'h0, rev_exp}, "revert");
      leave();
    end
    no_accept = 1'b0;
    $display("Test soft_reset_escalation done");
    for (int i = 0; i < 4; i++) begin
      role_is_src = i[0];
      fail_tx = i[1];
      st_q.push_back(pdsr_pkg::PDSR_ST_SOFT_RESET);
      msg_q.push_back(pdsr_pkg::PDSR_MSG_ACCEPT);
      if (i[1]) note_hr();
      else st_q.push_back(i[0] ? pdsr_pkg::PDSR_ST_SRC_SEND_CAPS
                               : pdsr_pkg::PDSR_ST_SNK_WAIT_CAPS);
      pulse(P_RXSR | (i[0] ? P_ERR : 8'h00));
      settle();
      leave();
    end
    fail_tx = 1'b0;
    $display("Test received_soft_reset done");
    prs = 1'b1;
    note_hr();
    pulse(P_ERR);
    settle();
    leave();
    prs = 1'b0;
    drs = 1'b1;
    seen_tcr = 1'b0;
    st_q.push_back(pdsr_pkg::PDSR_ST_ERR_RECOVERY);
    pulse(P_TXF);
    settle();
    chk_val({3'h0, seen_tcr}, 4'h1, "recovery");
    leave();
    drs = 1'b0;
    st_q.push_back(pdsr_pkg::PDSR_ST_SRC_SEND_CAPS);
    pulse(P_CAPS);
    settle();
    attached = 1'b0;
    st_q.push_back(pdsr_pkg::PDSR_ST_SRC_DISCOVERY);
    pulse(P_TXF);
    settle();
    leave();
    attached = 1'b1;
    $display("Test swap_and_discovery done");
    role_is_src = 1'b1;
    for (int i = 0; i < 2; i++) begin
      st_q.push_back(i ? pdsr_pkg::PDSR_ST_SRC_TRANS : pdsr_pkg::PDSR_ST_SRC_READY);
      pulse(i ? P_TRN : P_RDY);
      settle();
      seen_act = 1'b0;
      seen_ent = 1'b0;
      st_q.push_back(pdsr_pkg::PDSR_ST_SRC_PING);
      msg_q.push_back(pdsr_pkg::PDSR_MSG_PING);
      st_q.push_back(i ? pdsr_pkg::PDSR_ST_SRC_TRANS : pdsr_pkg::PDSR_ST_SRC_READY);
      pulse(P_PING);
      settle();
      chk_val({2'h0, seen_act, seen_ent}, 4'h2, "reentry");
      ping_en = 1'b0;
      pulse(P_PING);
      settle();
      ping_en = 1'b1;
      leave();
    end
    pulse(P_PING);
    settle();
    $display("Test source_ping done");
    end_sim();
  end
endmodule : tb
